// ---- lusc_pkg.sv ----
// Constants, encodings and register layout of the line unit serial command port.
// Assumes one system clock of 20 MHz on both ends; the serial link is sampled, not clocked on.
// Operation
// - Clock B invert picks data launch edge
// - Clock A invert picks data launch edge
// - Mode register bit four only drives mode_bit4
// - Rate bit picks DS3 or STS-1
// - E3 bit forces E3 mode
// - Loop bits decode to four loop modes
// - Host runs clock, frames with chip select
// - Device samples input on rising serial clock
// - Host shifts eight-bit header first
// - First header bit: one read, zero write
// - Bits two to five: address, LSB first
// - Host drives address bits four, five zero
// - Device ignores address bit six
// - Select bit picks violation flag or clock B
package lusc_pkg;
    localparam int         HDR_BITS        = 8;
    localparam int         DATA_BITS       = 8;
    localparam int         ADDR_BITS       = 4;
    localparam int         ADDR_LSB_POS    = 1;
    localparam logic [3:0] ADDR_CLK_CFG    = 4'h3;
    localparam logic [3:0] ADDR_MODE_CFG   = 4'h4;
    localparam logic [4:0] CLK_CFG_RESET   = 5'h00;
    localparam logic [4:0] MODE_CFG_RESET  = 5'h00;
    localparam int         CLK_A_INV_POS   = 0;
    localparam int         CLK_B_INV_POS   = 1;
    localparam int         CLK_B_SEL_POS   = 2;
    localparam int         LOOP_REMOTE_POS = 0;
    localparam int         LOOP_LOCAL_POS  = 1;
    localparam int         E3_SEL_POS      = 2;
    localparam int         RATE_SEL_POS    = 3;
    localparam logic [4:0] MODE_WR_MASK    = 5'h0f;
    localparam int         CLK_PERIOD_NS   = 50;
    localparam int         SCLK_PERIOD_NS  = 400;
    localparam int         SCLK_HALF_CYC   = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int         RCLK_HALF_CYC   = 2;

    typedef enum logic [1:0] {
        LUSC_RATE_DS3 = 2'h0,
        LUSC_RATE_STS1 = 2'h1,
        LUSC_RATE_E3 = 2'h2
    } lusc_rate_t;

    typedef enum logic [1:0] {
        LUSC_LOOP_NONE = 2'h0,
        LUSC_LOOP_REMOTE = 2'h1,
        LUSC_LOOP_ANALOG = 2'h2,
        LUSC_LOOP_DIGITAL = 2'h3
    } lusc_loop_t;

    typedef enum logic [3:0] {
        LUSC_IDLE = 4'b0001,
        LUSC_CS = 4'b0010,
        LUSC_SHIFT = 4'b0100,
        LUSC_DONE = 4'b1000
    } lusc_hst_t;
endpackage

// ---- lusc_if.sv ----
// Four-wire serial command link between host controller and line unit.
// Assumes both ends share the system clock; only the host drives the serial clock.
`timescale 1ns/1ps
interface lusc_if;
    logic sclk;
    logic cs_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    modport dev (input sclk, input cs_n, input serial_in, output serial_out, output serial_out_oe);
    modport host (output sclk, output cs_n, output serial_in, input serial_out, input serial_out_oe);
endinterface

// ---- lusc_sync.sv ----
// Two-stage synchroniser for single-bit inputs from outside the clock domain.
// Assumes a free-running system clock.
`timescale 1ns/1ps
module lusc_sync #(
    parameter int          WIDTH = 1,
    parameter logic [0:0]  INIT  = 1'h0
) (
    // System
    input  wire logic             clock,
    input  wire logic             nrst,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta <= {WIDTH{INIT}};
            dout <= {WIDTH{INIT}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // lusc_sync

// ---- lusc_dev.sv ----
// Device end: serial command port, two command registers and their effect.
// Assumes host keeps sclk slow against clock (>= 4 clock cycles per level).
`timescale 1ns/1ps
module lusc_dev
    import lusc_pkg::*;
(
    // System
    input  wire logic       clock,
    input  wire logic       nrst,
    // Serial link
    lusc_if.dev             link,
    // Receive side status
    input  wire logic       code_violation_flag,
    input  wire logic       recovered_data,
    // Configuration results
    output logic            recovered_clock_a_out,
    output logic            recovered_data_a,
    output logic            shared_pin_out,
    output logic            recovered_data_b,
    output lusc_pkg::lusc_rate_t rate_mode,
    output lusc_pkg::lusc_loop_t loop_mode,
    output logic            mode_bit4
);
    import lusc_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] pins_s;
    logic       cs_n_s;
    logic       lcv_s;
    logic       rdata_s;

    // Reset values match the idle pin levels, so no false edge follows reset
    lusc_sync #(.WIDTH(2), .INIT(1'h0)) u_sync_link (
        .clock (clock),
        .nrst  (nrst),
        .din   ({link.sclk, link.serial_in}),
        .dout  (pins_s)
    );
    lusc_sync #(.WIDTH(1), .INIT(1'h1)) u_sync_cs (
        .clock (clock),
        .nrst  (nrst),
        .din   (link.cs_n),
        .dout  (cs_n_s)
    );
    lusc_sync #(.WIDTH(2), .INIT(1'h0)) u_sync_rx (
        .clock (clock),
        .nrst  (nrst),
        .din   ({code_violation_flag, recovered_data}),
        .dout  ({lcv_s, rdata_s})
    );

    logic sclk_s;
    logic sdi_s;
    logic sclk_d;
    logic sclk_rise;
    logic sclk_fall;
    assign sclk_s    = pins_s[1];
    assign sdi_s     = pins_s[0];
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    always_ff @(posedge clock) begin
        if (!nrst) sclk_d <= 1'h0;
        else sclk_d <= sclk_s;
    end

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    logic [4:0]           bit_cnt;
    logic [HDR_BITS-1:0]  hdr;
    logic [DATA_BITS-1:0] wdata;
    logic [DATA_BITS-1:0] rshift;
    logic                 is_read;
    logic [ADDR_BITS-1:0] addr;
    logic [4:0]           clk_cfg;
    logic [4:0]           mode_cfg;
    logic [4:0]           rd_val;

    assign is_read = hdr[0];
    assign addr    = hdr[ADDR_LSB_POS +: ADDR_BITS];
    assign rd_val  = (addr == ADDR_CLK_CFG) ? clk_cfg : (addr == ADDR_MODE_CFG) ? mode_cfg : 5'h00;

    always_ff @(posedge clock) begin
        if (!nrst || cs_n_s) begin
            bit_cnt <= 5'h00;
            hdr     <= '0;
            wdata   <= '0;
        end else if (sclk_rise) begin
            if (bit_cnt < 5'(HDR_BITS)) hdr[bit_cnt[2:0]] <= sdi_s;
            else if (bit_cnt < 5'(HDR_BITS + DATA_BITS)) wdata <= {wdata[DATA_BITS-2:0], sdi_s};
            if (bit_cnt != 5'h1f) bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Read data leaves MSB first, launched on falling sclk; the host samples it on the next falling edge
    always_ff @(posedge clock) begin
        if (!nrst || cs_n_s) begin
            rshift             <= '0;
            link.serial_out    <= 1'h0;
            link.serial_out_oe <= 1'h0;
        end else if (sclk_fall && bit_cnt == 5'(HDR_BITS) && is_read) begin
            // Byte bit seven first; the three bits above the register read as zero
            link.serial_out    <= 1'h0;
            link.serial_out_oe <= 1'h1;
            rshift             <= {2'h0, rd_val, 1'h0};
        end else if (sclk_fall && link.serial_out_oe) begin
            link.serial_out <= rshift[DATA_BITS-1];
            rshift          <= {rshift[DATA_BITS-2:0], 1'h0};
        end
    end

    // ------------------------------------------------------------
    // Command registers
    // ------------------------------------------------------------
    logic wr_commit;
    assign wr_commit = sclk_rise && !cs_n_s && !is_read && bit_cnt == 5'(HDR_BITS + DATA_BITS - 1);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            clk_cfg  <= CLK_CFG_RESET;
            mode_cfg <= MODE_CFG_RESET;
        end else if (wr_commit) begin
            if (addr == ADDR_CLK_CFG) clk_cfg <= {wdata[3:0], sdi_s};
            if (addr == ADDR_MODE_CFG) mode_cfg <= {wdata[3:0], sdi_s};
        end
    end

    // Bit four is stored for readback and driven on mode_bit4; it sets no rate or loop mode
    assign mode_bit4 = mode_cfg[4];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rate_mode <= LUSC_RATE_DS3;
            loop_mode <= LUSC_LOOP_NONE;
        end else begin
            if (mode_cfg[E3_SEL_POS]) rate_mode <= LUSC_RATE_E3;
            else if (mode_cfg[RATE_SEL_POS]) rate_mode <= LUSC_RATE_STS1;
            else rate_mode <= LUSC_RATE_DS3;
            loop_mode <= lusc_loop_t'({mode_cfg[LOOP_LOCAL_POS], mode_cfg[LOOP_REMOTE_POS]});
        end
    end

    // ------------------------------------------------------------
    // Recovered clock and data launch
    // ------------------------------------------------------------
    logic [1:0] rdiv;
    logic       rclk;
    logic       rclk_rise;
    logic       rclk_fall;
    logic       data_b_raw;
    assign rclk_rise = (rdiv == 2'(RCLK_HALF_CYC - 1)) && !rclk;
    assign rclk_fall = (rdiv == 2'(RCLK_HALF_CYC - 1)) && rclk;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdiv <= 2'h0;
            rclk <= 1'h0;
        end else if (rdiv == 2'(RCLK_HALF_CYC - 1)) begin
            rdiv <= 2'h0;
            rclk <= ~rclk;
        end else begin
            rdiv <= rdiv + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            recovered_clock_a_out <= 1'h0;
            recovered_data_a      <= 1'h0;
            recovered_data_b      <= 1'h0;
            shared_pin_out        <= 1'h0;
        end else begin
            recovered_clock_a_out <= rclk_rise ? 1'h1 : rclk_fall ? 1'h0 : recovered_clock_a_out;
            if (clk_cfg[CLK_A_INV_POS] ? rclk_fall : rclk_rise) recovered_data_a <= rdata_s;
            if (clk_cfg[CLK_B_INV_POS] ? rclk_fall : rclk_rise) recovered_data_b <= rdata_s;
            if (clk_cfg[CLK_B_SEL_POS])
                shared_pin_out <= rclk_rise ? 1'h1 : rclk_fall ? 1'h0 : shared_pin_out;
            else
                shared_pin_out <= lcv_s;
        end
    end
endmodule // lusc_dev

// ---- lusc_host.sv ----
// Host end: makes the serial clock, frames one transaction per command.
// Assumes a single system clock; the device answers on the falling serial edge.
`timescale 1ns/1ps
module lusc_host
    import lusc_pkg::*;
(
    // System
    input  wire logic       clock,
    input  wire logic       nrst,
    // Serial link
    lusc_if.host            link,
    // Command port
    input  wire logic       start,
    input  wire logic       rd,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rdata
);
    import lusc_pkg::*;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    lusc_hst_t            state;
    logic [2:0]           div;
    logic [4:0]           bit_cnt;
    logic [15:0]          shift;
    logic                 half;
    logic [1:0]           sdo_s;
    assign half = (div == 3'(SCLK_HALF_CYC - 1));

    always_ff @(posedge clock) begin
        if (!nrst) sdo_s <= 2'h0;
        else sdo_s <= {sdo_s[0], link.serial_out};
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= LUSC_IDLE;
            div <= 3'h0;
            bit_cnt <= 5'h00;
            shift <= 16'h0000;
            link.sclk <= 1'h0;
            link.cs_n <= 1'h1;
            link.serial_in <= 1'h0;
            busy <= 1'h0;
            done <= 1'h0;
            rdata <= 8'h00;
        end else begin
            done <= 1'h0;
            div <= half ? 3'h0 : div + 3'h1;
            case (state)
                LUSC_IDLE: begin
                    if (start) begin
                        // Header: direction, address LSB first, two zeros, don't-care zero
                        shift <= {wdata, 1'h0, 2'h0, addr[3], addr[2], addr[1], addr[0], rd};
                        busy <= 1'h1;
                        div <= 3'h0;
                        link.cs_n <= 1'h0;
                        state <= LUSC_CS;
                    end
                end
                LUSC_CS: begin
                    if (half) begin
                        link.serial_in <= shift[0];
                        shift <= {1'h0, shift[15:1]};
                        state <= LUSC_SHIFT;
                    end
                end
                LUSC_SHIFT: begin
                    if (half) begin
                        link.sclk <= ~link.sclk;
                        if (link.sclk) begin
                            link.serial_in <= (bit_cnt >= 5'd8) ? shift[7] : shift[0];
                            if (bit_cnt >= 5'd8) shift <= {shift[14:0], 1'h0};
                            else shift <= {1'h0, shift[15:1]};
                            // Sampled on the falling edge: device launch plus synchroniser lag exceeds a half period
                            if (bit_cnt >= 5'd9) rdata <= {rdata[6:0], sdo_s[1]};
                            if (bit_cnt == 5'd16) state <= LUSC_DONE;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                LUSC_DONE: begin
                    if (half) begin
                        link.cs_n <= 1'h1;
                        bit_cnt <= 5'h00;
                        busy <= 1'h0;
                        done <= 1'h1;
                        state <= LUSC_IDLE;
                    end
                end
                default: state <= LUSC_IDLE;
            endcase
        end
    end
endmodule // lusc_host

// ---- lusc_chk.sv ----
// Checker for the serial command link between host and device ends.
// Assumes it sits beside the link interface, on the shared system clock.
`timescale 1ns/1ps
module lusc_chk (
    // System
    input wire logic clock,
    input wire logic nrst,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // ----
    // Edge counting
    // ----
    logic       sclk_q;
    logic [4:0] n_rise;
    wire        rise = sclk && !sclk_q;
    always_ff @(posedge clock) begin
        sclk_q <= nrst ? sclk : 1'h0;
    end
    // Raw edges, not synchronised ones, so the count shows what the wire did
    always_ff @(posedge clock) begin
        if (!nrst || cs_n) begin
            n_rise <= 5'h00;
        end else if (rise) begin
            n_rise <= n_rise + 5'h01;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_idle; cs_n |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("serial clock moves outside a frame");
    property p_setup; $fell(cs_n) |-> !sclk[*6]; endproperty
    a_setup: assert property (p_setup) else $error("first serial edge too close to frame start");
    property p_high; $rose(sclk) |-> sclk[*4] ##1 !sclk; endproperty
    a_high: assert property (p_high) else $error("serial clock high phase not four cycles");
    property p_hold; sclk && sclk_q |-> $stable(serial_in); endproperty
    a_hold: assert property (p_hold) else $error("serial input moved while clock high");
    property p_frame; $rose(cs_n) |-> n_rise == 5'h10; endproperty
    a_frame: assert property (p_frame) else $error("frame is not sixteen edges");
    property p_zero; rise && (n_rise == 5'h05 || n_rise == 5'h06) |-> !serial_in; endproperty
    a_zero: assert property (p_zero) else $error("upper address bits not zero");
    property p_oe_start; $rose(serial_out_oe) |-> n_rise == 5'h08; endproperty
    a_oe_start: assert property (p_oe_start) else $error("read data driven before header end");
    property p_oe_end; $rose(cs_n) |-> ##[1:4] !serial_out_oe; endproperty
    a_oe_end: assert property (p_oe_end) else $error("output still driven after frame end");
    property p_out_hold; serial_out_oe && sclk && sclk_q |-> $stable(serial_out); endproperty
    a_out_hold: assert property (p_out_hold) else $error("read data moved while clock high");
endmodule // lusc_chk

// ---- line_unit_serial_cmd_port_test.sv ----
// Testbench: host and device ends joined by the link, driven through the host command port.
// Assumes one 20 MHz clock for both ends; the host makes the serial clock.
`timescale 1ns/1ps
module line_unit_serial_cmd_port_test;
    import lusc_pkg::*;
    logic       clock = 1'h0;
    logic       nrst = 1'h0;
    logic       start = 1'h0;
    logic       rd = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       cvf = 1'h0;
    logic       rdat = 1'h0;
    logic       busy, done, clk_a, dat_a, shared, dat_b, bit4;
    logic [7:0] rdata;
    lusc_rate_t rate;
    lusc_loop_t loop;
    int         n_mismatch = 0;
    int         total_checks = 0;
    lusc_if link ();
    lusc_host lusc_host_inst (.clock(clock), .nrst(nrst), .link(link), .start(start), .rd(rd), .addr(addr),
        .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
    lusc_dev lusc_dev_inst (.clock(clock), .nrst(nrst), .link(link), .code_violation_flag(cvf),
        .recovered_data(rdat), .recovered_clock_a_out(clk_a), .recovered_data_a(dat_a), .shared_pin_out(shared),
        .recovered_data_b(dat_b), .rate_mode(rate), .loop_mode(loop), .mode_bit4(bit4));
    lusc_chk lusc_chk_inst (.clock(clock), .nrst(nrst), .sclk(link.sclk), .cs_n(link.cs_n),
        .serial_in(link.serial_in), .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe));
    always #25 clock = ~clock;
    // Data period of six clocks drifts against the four-clock recovered clock
    always begin
        repeat (3) @(posedge clock);
        rdat <= ~rdat;
    end
    // ----
    // Tasks
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One whole transaction; done is seen one edge late, rdata holds from then on
    task automatic cmd(input logic r, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        start <= 1'h1;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        start <= 1'h0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n == 1) check({7'h00, busy}, 8'h01);
        end while (done !== 1'h1 && n < 400);
        check({7'h00, busy}, 8'h00);
        if (n >= 400) begin
            n_mismatch++;
        end
    endtask
    task automatic scan(input logic [7:0] cfg);
        logic pa, pb, pt;
        int   na, nb, nt;
        cmd(1'h0, ADDR_CLK_CFG, cfg);
        na = 0;
        nb = 0;
        nt = 0;
        @(negedge clock);
        pa = dat_a;
        pb = dat_b;
        pt = shared;
        repeat (80) begin
            @(negedge clock);
            if (dat_a !== pa) begin
                check({7'h00, clk_a}, {7'h00, ~cfg[0]});
                na++;
            end
            if (dat_b !== pb) begin
                check({7'h00, shared}, {7'h00, ~cfg[1]});
                nb++;
            end
            if (shared !== pt) begin
                nt++;
            end
            pa = dat_a;
            pb = dat_b;
            pt = shared;
        end
        check({7'h00, na != 0 && nb != 0}, 8'h01);
        check({7'h00, nt > 10}, 8'h01);
    endtask
    // ----
    // Tests
    // ----
    initial begin
        #3000000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'h1;
        repeat (4) @(posedge clock);
        cmd(1'h1, ADDR_CLK_CFG, 8'h00);
        check(rdata, {3'h0, CLK_CFG_RESET});
        cmd(1'h1, ADDR_MODE_CFG, 8'h00);
        check(rdata, {3'h0, MODE_CFG_RESET});
        check({6'h00, rate}, 8'h00);
        $display("reset test done");
        for (int i = 0; i < 32; i++) begin
            cmd(1'h0, ADDR_MODE_CFG, 8'(i));
            check({6'h00, loop}, 8'(i % 4));
            check({6'h00, rate}, i[2] ? 8'h02 : 8'(i[3]));
            cmd(1'h1, ADDR_MODE_CFG, 8'h00);
            check(rdata, 8'(i));
            check({7'h00, bit4}, {7'h00, i[4]});
        end
        $display("mode test done");
        cmd(1'h0, ADDR_CLK_CFG, 8'hff);
        cmd(1'h0, 4'hb, 8'h00);
        cmd(1'h0, 4'h5, 8'hff);
        cmd(1'h1, ADDR_CLK_CFG, 8'h00);
        check(rdata, 8'h1f);
        cmd(1'h1, 4'h5, 8'h00);
        check(rdata, 8'h00);
        cmd(1'h1, ADDR_MODE_CFG, 8'h00);
        check(rdata, 8'h1f);
        $display("address test done");
        for (int c = 4; c < 8; c++) begin
            scan(8'(c));
        end
        cmd(1'h0, ADDR_CLK_CFG, 8'h00);
        cvf <= 1'h1;
        repeat (6) @(posedge clock);
        check({7'h00, shared}, 8'h01);
        cvf <= 1'h0;
        repeat (6) @(posedge clock);
        check({7'h00, shared}, 8'h00);
        $display("receive clock test done");
        stop_test();
    end
endmodule // line_unit_serial_cmd_port_test
